// >>> shared/gpt_defines.svh
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH
// register byte offsets on the apb bus
`define GPT_OFF_LOW_COUNT   12'h000
`define GPT_OFF_HOLD        12'h004
`define GPT_OFF_HIGH_COUNT  12'h008
`define GPT_OFF_LOW_PERIOD  12'h00C
`define GPT_OFF_HIGH_PERIOD 12'h010
`define GPT_OFF_FIRST_CTRL  12'h014
`define GPT_OFF_SECOND_CTRL 12'h018
`define GPT_OFF_IRQ         12'h01C
// control field positions
`define GPT_B_ON            15
`define GPT_B_SIDL          13
`define GPT_B_GATE          6
`define GPT_B_PS_HI         5
`define GPT_B_PS_LO         4
`define GPT_B_CASCADE       3
`define GPT_B_CSRC          1
// writable control bits
`define GPT_CTRL_MASK       16'hA07A
// irq register fields
`define GPT_B_IRQ_FLAG      0
`define GPT_B_IRQ_EN        1
// reset values
`define GPT_PERIOD_RST      16'hFFFF
`define GPT_ZERO16          16'h0000
`define GPT_ONE16           16'h0001
// prescale terminal counts (ratio minus one)
`define GPT_PS_DIV1         8'h00
`define GPT_PS_DIV8         8'h07
`define GPT_PS_DIV64        8'h3F
`define GPT_PS_DIV256       8'hFF
`define GPT_ZERO8           8'h00
`define GPT_ONE8            8'h01
`endif

// >>> shared/gpt_pkg.sv
package gpt_pkg;
  // per-timer decoded control word
  typedef struct packed {
    logic       on;
    logic       sidl;
    logic       gate;
    logic [1:0] ps;
    logic       cascade;
    logic       csrc;
  } gpt_ctrl_t;
  // time base handed to capture and compare peripherals
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } gpt_base_t;
endpackage

// >>> logic/gpt_timer.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "gpt_defines.svh"

// Summary of operation
// - cascade: first timer low, second high half
// - cascaded timer counts cycles, wraps at period
// - low read latches high half into hold
// - in cascade, hold write then low write loads high
// - cascaded counter counts synced external edges
// - stop in idle halts counter mode
// - uncascaded timers run independently, 16-bit each
// - no asynchronous counter mode exists
// - only first timer syncs prescaler output
// - cascade ignores second control register
// - cascade irq via second flag and enable
// - gate high enables cycle counting
// - cascade gating from first timer only
// - gate fall stops count, keeps value
// - counts exported as capture/compare time bases
// - second timer emits converter trigger on match
// - prescale 1, 8, 64 or 256
// - prescaler clears on count write, off, reset
// - second or 32-bit match, or cascade gate fall, sets flag; software clears
module gpt_timer
  import gpt_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        CPU_IDLE_I,
  input  wire logic        EXT_CLOCK_GATE_PIN_I,
  input  wire logic        EXT_CLOCK_SECOND_PIN_I,
  output gpt_base_t        TIME_BASE_O,
  output logic             MATCH_IRQ_O,
  output logic             ADC_TRIGGER_O
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic gpt_ctrl_t dec_ctrl(input logic [15:0] w);
    dec_ctrl.on      = w[`GPT_B_ON];
    dec_ctrl.sidl    = w[`GPT_B_SIDL];
    dec_ctrl.gate    = w[`GPT_B_GATE];
    dec_ctrl.ps      = w[`GPT_B_PS_HI:`GPT_B_PS_LO];
    dec_ctrl.cascade = w[`GPT_B_CASCADE];
    dec_ctrl.csrc    = w[`GPT_B_CSRC];
  endfunction

  function automatic logic [7:0] ps_term(input logic [1:0] sel);
    case (sel)
      2'b00:   ps_term = `GPT_PS_DIV1;
      2'b01:   ps_term = `GPT_PS_DIV8;
      2'b10:   ps_term = `GPT_PS_DIV64;
      default: ps_term = `GPT_PS_DIV256;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0] cnt_r     [2];
  logic [15:0] cnt_nxt   [2];
  logic [15:0] per_r     [2];
  logic [15:0] per_nxt   [2];
  logic [15:0] ctl_r     [2];
  logic [15:0] ctl_nxt   [2];
  logic [7:0]  psc_r     [2];
  logic [7:0]  psc_nxt   [2];
  logic [1:0]  ext_d_r;
  logic [1:0]  ext_q_r;
  logic [1:0]  ext_p_r;
  logic [1:0]  tick_r;
  logic [1:0]  tick_nxt;
  logic [15:0] hold_r,    hold_nxt;
  logic        gate_p_r;
  logic        flag_r,    flag_nxt;
  logic        ien_r,     ien_nxt;
  logic        trig_r,    trig_nxt;
  logic [31:0] rdata_r,   rdata_nxt;

  gpt_ctrl_t   c0, c1, ce [2];
  logic        casc;
  logic        wr, rd;
  logic [1:0]  wr_cnt;
  logic [1:0]  wr_ctl;
  logic [1:0]  wr_per;
  logic [1:0]  src;
  logic [1:0]  run;
  logic [1:0]  edge_ext;
  logic [1:0]  inc;
  logic [1:0]  match;
  logic        gate_fall;
  logic        match32;

  assign c0   = dec_ctrl(ctl_r[0]);
  assign c1   = dec_ctrl(ctl_r[1]);
  assign casc = c0.cascade;
  // cascade takes all setup from the first control word
  assign ce[0] = c0;
  assign ce[1] = casc ? c0 : c1;

  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd = PSEL_I & ~PENABLE_I & ~PWRITE_I; // setup: data stands at access

  ////////////////////////////////////////////////////////////////////////////
  // external clock sync; pins assumed synchronous, two stages absorb slop

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ext_d_r  <= 2'b00;
      ext_q_r  <= 2'b00;
      ext_p_r  <= 2'b00;
      gate_p_r <= 1'b0;
    end else begin
      ext_d_r  <= {EXT_CLOCK_SECOND_PIN_I, EXT_CLOCK_GATE_PIN_I};
      ext_q_r  <= ext_d_r;
      ext_p_r  <= ext_q_r;
      gate_p_r <= ext_q_r[0];
    end
  end

  // rising clock edges, falling gate edge; no asynchronous path exists in any mode
  assign edge_ext  = ext_q_r & ~ext_p_r;
  assign gate_fall = gate_p_r & ~ext_q_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // per-timer prescaler and count enables

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      // in cascade both halves use the first pin and first prescaler
      assign src[g] = ce[g].csrc ? edge_ext[casc ? 0 : g] : 1'b1;
      // gate pin only steers the first timer or a cascaded pair
      assign run[g] = ce[g].on & ~(ce[g].sidl & CPU_IDLE_I)
                    & (~ce[g].gate | ce[g].csrc
                       | ext_q_r[casc ? 0 : g]);
      assign match[g] = (cnt_r[g] == per_r[g]);
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      psc_nxt[i]  = psc_r[i];
      tick_nxt[i] = 1'b0;
      if (!ce[i].on || wr_cnt[i]) begin
        psc_nxt[i] = `GPT_ZERO8;
      end else if (run[i] && src[i]) begin
        if (psc_r[i] >= ps_term(ce[i].ps)) begin
          psc_nxt[i]  = `GPT_ZERO8;
          tick_nxt[i] = 1'b1;
        end else begin
          psc_nxt[i] = psc_r[i] + `GPT_ONE8;
        end
      end
    end
  end

  // first timer re-times its prescaler output by a flop; second is direct
  assign inc[0] = tick_r[0];
  assign inc[1] = casc ? tick_r[0] : tick_nxt[1];
  assign match32 = match[0] & match[1];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  always_comb begin
    wr_cnt = 2'b00;
    wr_ctl = 2'b00;
    wr_per = 2'b00;
    if (wr && PADDR_I == `GPT_OFF_LOW_COUNT) begin
      wr_cnt = 2'b01;
    end else if (wr && PADDR_I == `GPT_OFF_HIGH_COUNT) begin
      wr_cnt = 2'b10;
    end else if (wr && PADDR_I == `GPT_OFF_LOW_PERIOD) begin
      wr_per = 2'b01;
    end else if (wr && PADDR_I == `GPT_OFF_HIGH_PERIOD) begin
      wr_per = 2'b10;
    end else if (wr && PADDR_I == `GPT_OFF_FIRST_CTRL) begin
      wr_ctl = 2'b01;
    end else if (wr && PADDR_I == `GPT_OFF_SECOND_CTRL) begin
      wr_ctl = 2'b10;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters, registers, flag

  always_comb begin
    cnt_nxt  = cnt_r;
    per_nxt  = per_r;
    ctl_nxt  = ctl_r;
    hold_nxt = hold_r;
    flag_nxt = flag_r;
    ien_nxt  = ien_r;
    trig_nxt = 1'b0;
    // counting
    if (casc) begin
      if (inc[0]) begin
        if (match32) begin
          cnt_nxt[0] = `GPT_ZERO16;
          cnt_nxt[1] = `GPT_ZERO16;
          trig_nxt   = 1'b1;
        end else begin
          cnt_nxt[0] = cnt_r[0] + `GPT_ONE16;
          if (cnt_r[0] == `GPT_PERIOD_RST) begin
            cnt_nxt[1] = cnt_r[1] + `GPT_ONE16;
          end
        end
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (inc[i]) begin
          cnt_nxt[i] = match[i] ? `GPT_ZERO16
                                : cnt_r[i] + `GPT_ONE16;
        end
      end
      trig_nxt = inc[1] & match[1];
    end
    // software writes take priority over counting
    for (int i = 0; i < 2; i++) begin
      if (wr_per[i]) per_nxt[i] = PWDATA_I[15:0];
      // count is untouched by control writes
      if (wr_ctl[i]) ctl_nxt[i] = PWDATA_I[15:0] & `GPT_CTRL_MASK;
    end
    if (wr_cnt[0]) begin
      cnt_nxt[0] = PWDATA_I[15:0];
      if (casc) cnt_nxt[1] = hold_r;
    end
    if (wr_cnt[1]) cnt_nxt[1] = PWDATA_I[15:0];
    if (wr && PADDR_I == `GPT_OFF_HOLD) hold_nxt = PWDATA_I[15:0];
    if (rd && PADDR_I == `GPT_OFF_LOW_COUNT) hold_nxt = cnt_r[1];
    // flag: software write-one clears, a new event wins
    if (wr && PADDR_I == `GPT_OFF_IRQ) begin
      ien_nxt = PWDATA_I[`GPT_B_IRQ_EN];
      if (PWDATA_I[`GPT_B_IRQ_FLAG]) flag_nxt = 1'b0;
    end
    if ((casc && inc[0] && match32) || (casc && c0.gate && gate_fall)
        || (!casc && inc[1] && match[1])) begin
      flag_nxt = 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (rd) begin
      rdata_nxt = 32'h0000_0000;
      if (PADDR_I == `GPT_OFF_LOW_COUNT) begin
        rdata_nxt[15:0] = cnt_r[0];
      end else if (PADDR_I == `GPT_OFF_HOLD) begin
        rdata_nxt[15:0] = hold_r;
      end else if (PADDR_I == `GPT_OFF_HIGH_COUNT) begin
        rdata_nxt[15:0] = cnt_r[1];
      end else if (PADDR_I == `GPT_OFF_LOW_PERIOD) begin
        rdata_nxt[15:0] = per_r[0];
      end else if (PADDR_I == `GPT_OFF_HIGH_PERIOD) begin
        rdata_nxt[15:0] = per_r[1];
      end else if (PADDR_I == `GPT_OFF_FIRST_CTRL) begin
        rdata_nxt[15:0] = ctl_r[0];
      end else if (PADDR_I == `GPT_OFF_SECOND_CTRL) begin
        rdata_nxt[15:0] = ctl_r[1];
      end else if (PADDR_I == `GPT_OFF_IRQ) begin
        rdata_nxt[`GPT_B_IRQ_FLAG] = flag_r;
        rdata_nxt[`GPT_B_IRQ_EN]   = ien_r;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < 2; i++) begin
        cnt_r[i] <= `GPT_ZERO16;
        per_r[i] <= `GPT_PERIOD_RST;
        ctl_r[i] <= `GPT_ZERO16;
        psc_r[i] <= `GPT_ZERO8;
      end
      tick_r  <= 2'b00;
      hold_r  <= `GPT_ZERO16;
      flag_r  <= 1'b0;
      ien_r   <= 1'b0;
      trig_r  <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      cnt_r   <= cnt_nxt;
      per_r   <= per_nxt;
      ctl_r   <= ctl_nxt;
      psc_r   <= psc_nxt;
      tick_r  <= tick_nxt;
      hold_r  <= hold_nxt;
      flag_r  <= flag_nxt;
      ien_r   <= ien_nxt;
      trig_r  <= trig_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; zero wait states

  assign PREADY_O      = 1'b1;
  assign PSLVERR_O     = 1'b0;
  assign PRDATA_O      = rdata_r;
  assign TIME_BASE_O   = {cnt_r[1], cnt_r[0]};
  assign MATCH_IRQ_O   = flag_r & ien_r;
  assign ADC_TRIGGER_O = trig_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_HOLD_LATCH: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    rd && PADDR_I == `GPT_OFF_LOW_COUNT |=> hold_r == $past(cnt_r[1]))
    else $error("hold did not latch high half");

  AST_COH_WRITE: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    wr_cnt[0] && casc |=> cnt_r[1] == $past(hold_r))
    else $error("high half not loaded from hold");

  AST_CASC_WRAP: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    casc && inc[0] && match32 && !wr_cnt[0] && !wr_cnt[1]
    |=> TIME_BASE_O == 32'h0000_0000 && trig_r)
    else $error("cascaded count did not wrap");

  AST_CTRL_KEEP: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    wr_ctl != 2'b00 && !inc[0] && !inc[1] |=> $stable(TIME_BASE_O))
    else $error("control write changed count");

  AST_PSC_CLR: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    wr_cnt[0] |=> psc_r[0] == `GPT_ZERO8)
    else $error("prescaler not cleared");

  AST_IDLE_STOP: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    c1.sidl && CPU_IDLE_I && !casc |-> !inc[1])
    else $error("counted during idle");

  AST_GATE_HOLD: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    c0.gate && !c0.csrc && !ext_q_r[0] |-> !tick_nxt[0])
    else $error("counted with gate low");

  AST_FLAG_SET: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    casc && c0.gate && gate_fall |=> flag_r)
    else $error("gate fall did not set flag");

  AST_IND_WRAP: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !casc && inc[1] && match[1] && !wr_cnt[1] |=> cnt_r[1] == `GPT_ZERO16)
    else $error("second timer did not wrap");

endmodule

// >>> verification/gpt_pin_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// far-side pin source: clean external clock edges and a gate window
module gpt_pin_model (
  input  wire logic clk_i,
  output logic      gate_pin_o,
  output logic      second_pin_o
);
  // both pins idle low, the lines have no pull and only the pulses and gate_high tasks toggle them
  initial begin
    gate_pin_o   = 1'b0;
    second_pin_o = 1'b0;
  end
  // each level is held at least 4 cycles so the 2-flop sync never misses it
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      second_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      second_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // gate held high for exactly n cycles, then dropped
  task automatic gate_high(input int n);
    @(posedge clk_i);
    gate_pin_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    gate_pin_o <= 1'b0;
  endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
`include "gpt_defines.svh"
////////////////////////////////////////////////////////////////////////////
module tb;
  import gpt_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, idle;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lo;
  logic        pready, pslverr, irq, trig, gate_pin, sec_pin;
  gpt_base_t   tb_base;
  int          num_errors, num_checks, cyc, n;
  gpt_timer dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CPU_IDLE_I(idle),
    .EXT_CLOCK_GATE_PIN_I(gate_pin), .EXT_CLOCK_SECOND_PIN_I(sec_pin),
    .TIME_BASE_O(tb_base), .MATCH_IRQ_O(irq), .ADC_TRIGGER_O(trig));
  gpt_pin_model u_pins (.clk_i(clk), .gate_pin_o(gate_pin),
    .second_pin_o(sec_pin));
  ////////////////////////////////////////////////////////////////////////
  // clock, plus a cycle ceiling so a hung wait cannot stall the run
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one apb transfer; read data is taken at the edge that sees pready,
  // then one idle edge so back-to-back calls never rewrite psel at once
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("base at reset", tb_base, 32'h0000_0000);
    check("irq at reset", irq, 1'b0);
    check("trigger at reset", trig, 1'b0);
    rdr(`GPT_OFF_LOW_PERIOD);
    check("low_period", rd, 32'h0000_FFFF);
    rdr(`GPT_OFF_FIRST_CTRL);
    check("first_control", rd, 32'h0000_0000);
    rdr(12'h040);
    check("unmapped", rd, 32'h0000_0000);
    check("no slave error", pslverr, 1'b0);
  endtask
  // frozen pair first: hold then low loads both halves; then a live read
  task automatic t_coherent();
    logic [31:0] hi;
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_0008);
    wr(`GPT_OFF_HOLD, 32'h0000_0001);
    wr(`GPT_OFF_LOW_COUNT, 32'h0000_FFFE);
    rdr(`GPT_OFF_HIGH_COUNT);
    check("high loaded", rd, 32'h0000_0001);
    check("pair", tb_base, 32'h0001_FFFE);
    wr(`GPT_OFF_HOLD, 32'h0000_0000);
    rdr(`GPT_OFF_LOW_COUNT);
    check("low frozen", rd, 32'h0000_FFFE);
    rdr(`GPT_OFF_HOLD);
    check("hold frozen", rd, 32'h0000_0001);
    // live read next to the carry: both halves must form one count
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_8008);
    @(posedge clk);
    rdr(`GPT_OFF_LOW_COUNT);
    lo = rd;
    rdr(`GPT_OFF_HOLD);
    hi = {rd[15:0], lo[15:0]} - 32'h0001_FFFE;
    check("coherent", 32'(hi < 32'h0000_0020), 32'h1);
  endtask
  // 32-bit period 9: one trigger every 10 cycles, irq via second flag
  task automatic t_wrap();
    logic [31:0] mx;
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_0000);
    wr(`GPT_OFF_SECOND_CTRL, 32'h0000_8070);
    wr(`GPT_OFF_LOW_PERIOD, 32'h0000_0009);
    wr(`GPT_OFF_HIGH_PERIOD, 32'h0000_0000);
    wr(`GPT_OFF_LOW_COUNT, 32'h0000_0000);
    wr(`GPT_OFF_HIGH_COUNT, 32'h0000_0000);
    wr(`GPT_OFF_IRQ, 32'h0000_0002);
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_8008);
    repeat (20) @(posedge clk);
    n  = 0;
    mx = 0;
    // sampled between edges so a registered pulse is never raced
    repeat (100) begin
      @(negedge clk);
      if (trig === 1'b1) n++;
      if (tb_base > mx) mx = tb_base;
    end
    @(posedge clk);
    check("triggers", n, 10);
    check("max count", mx, 32'h0000_0009);
    check("irq set", irq, 1'b1);
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_0000);
    wr(`GPT_OFF_IRQ, 32'h0000_0003);
    check("irq clear", irq, 1'b0);
    wr(`GPT_OFF_SECOND_CTRL, 32'h0000_0000);
  endtask
  // second timer alone as counter, halted while idle, then wrapping
  task automatic t_counter();
    wr(`GPT_OFF_HIGH_PERIOD, 32'h0000_FFFF);
    wr(`GPT_OFF_HIGH_COUNT, 32'h0000_0000);
    wr(`GPT_OFF_SECOND_CTRL, 32'h0000_8002);
    u_pins.pulses(5);
    repeat (6) @(posedge clk);
    check("second count", tb_base.high, 32'h0000_0005);
    wr(`GPT_OFF_SECOND_CTRL, 32'h0000_A002);
    idle <= 1'b1;
    u_pins.pulses(3);
    idle <= 1'b0;
    u_pins.pulses(2);
    repeat (6) @(posedge clk);
    check("idle count", tb_base.high, 32'h0000_0007);
    wr(`GPT_OFF_HIGH_PERIOD, 32'h0000_0007);
    u_pins.pulses(1);
    repeat (6) @(posedge clk);
    check("second wrap", tb_base.high, 32'h0000_0000);
    wr(`GPT_OFF_SECOND_CTRL, 32'h0000_0000);
    wr(`GPT_OFF_IRQ, 32'h0000_0003);
  endtask
  // cascaded gate: second control's gate is ignored, a fall sets the flag
  task automatic t_casc_gate();
    wr(`GPT_OFF_LOW_PERIOD, 32'h0000_FFFF);
    wr(`GPT_OFF_HIGH_PERIOD, 32'h0000_FFFF);
    wr(`GPT_OFF_LOW_COUNT, 32'h0000_0000);
    wr(`GPT_OFF_HIGH_COUNT, 32'h0000_0000);
    wr(`GPT_OFF_SECOND_CTRL, 32'h0000_0040);
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_8048);
    check("irq before gate", irq, 1'b0);
    u_pins.gate_high(12);
    repeat (6) @(posedge clk);
    check("cascade gate sum", tb_base, 32'h0000_000C);
    check("gate fall irq", irq, 1'b1);
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_0000);
    wr(`GPT_OFF_IRQ, 32'h0000_0000);
    check("irq masked", irq, 1'b0);
    rdr(`GPT_OFF_IRQ);
    check("flag kept", rd, 32'h0000_0001);
    wr(`GPT_OFF_IRQ, 32'h0000_0003);
    rdr(`GPT_OFF_IRQ);
    check("flag cleared", rd, 32'h0000_0002);
    wr(`GPT_OFF_SECOND_CTRL, 32'h0000_0000);
  endtask
  // gated accumulation of 20 cycles, kept after the gate falls
  task automatic t_gate();
    wr(`GPT_OFF_LOW_PERIOD, 32'h0000_FFFF);
    wr(`GPT_OFF_LOW_COUNT, 32'h0000_0000);
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_8040);
    u_pins.gate_high(20);
    repeat (6) @(posedge clk);
    lo = tb_base.low;
    check("gate sum", lo, 32'h0000_0014);
    repeat (10) @(posedge clk);
    check("gate kept", tb_base.low, lo);
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_0000);
    wr(`GPT_OFF_LOW_COUNT, 32'h0000_0000);
    wr(`GPT_OFF_FIRST_CTRL, 32'h0000_8010);
    repeat (160) @(posedge clk);
    // read off the edge: the twentieth step lands on the last edge
    @(negedge clk);
    lo = tb_base.low;
    check("div 8", lo, 32'h0000_0014);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    idle    = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_coherent();
    t_wrap();
    t_counter();
    t_casc_gate();
    t_gate();
    give_verdict();
  end
endmodule
